// ===== rtl/qpm_pkg.sv
package qpm_pkg;

    localparam int NUM_CHAN = 4;
    localparam int NUM_ENGINE = 2;
    localparam int BUS_W = 8;

    // Bit positions on each channel bus, UART function.
    localparam int UART_TX_BIT = 0;
    localparam int UART_RX_BIT = 1;
    localparam int UART_RTS_BIT = 2;
    localparam int UART_CTS_BIT = 3;
    localparam int UART_DTR_BIT = 4;
    localparam int UART_DSR_BIT = 5;
    localparam int UART_DCD_BIT = 6;
    localparam int UART_RING_BIT = 7;

    // Bit positions on each channel bus, serial engine function.
    localparam int ENG_CLK_BIT = 0;
    localparam int ENG_DOUT_BIT = 1;
    localparam int ENG_DIN_BIT = 2;
    localparam int ENG_SEL_BIT = 3;
    localparam int ENG_GPIO_LSB = 4;

    // Output enable patterns per function, and the bus output value loaded at reset.
    localparam logic [7:0] UART_OE_BASE = 8'h15;
    localparam logic [7:0] ENG_OE_BASE = 8'h0b;
    localparam logic [7:0] BUS_RESET_OUT = 8'hff;

    // Reset value of the channel mode field.
    localparam logic [1:0] MODE_RESET = 2'h0;

    typedef enum logic [1:0] {
        QPM_MODE_UART = 2'h0,
        QPM_MODE_BB_ASYNC = 2'h1,
        QPM_MODE_BB_SYNC = 2'h2,
        QPM_MODE_ENGINE = 2'h3
    } qpm_mode_t;

    // Per-channel configuration coming from the configuration memory.
    typedef struct packed {
        qpm_mode_t mode;
        logic lineDriverSel;
        logic wakeEnable;
        logic wakePulldown;
    } qpm_cfg_t;

    // Function-side outputs for one channel.
    typedef struct packed {
        logic uartTx;
        logic uartRtsN;
        logic uartDtrN;
        logic lineDriverEnable;
        logic engineClockOut;
        logic engineDataOut;
        logic engineSelect;
        logic [3:0] engineGpioOut;
        logic [3:0] engineGpioOe;
        logic [7:0] bitbangOut;
        logic [7:0] bitbangOe;
    } qpm_fn_out_t;

    // Function-side inputs returned for one channel.
    typedef struct packed {
        logic uartRx;
        logic uartCtsN;
        logic uartDsrN;
        logic carrierDetectN;
        logic ringIndicateN;
        logic engineDataIn;
        logic [3:0] engineGpioIn;
        logic [7:0] bitbangIn;
    } qpm_fn_in_t;

    localparam int FN_IN_W = $bits(qpm_fn_in_t);

endpackage : qpm_pkg

// ===== rtl/qpm_fifo.sv
`timescale 1ns/100ps
module qpm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWrite;
    logic doRead;

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRead && !doWrite) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : qpm_fifo

// ===== rtl/qpm_pin_mux.sv
`timescale 1ns/100ps
// What this block does
// [R1] Each of four channels can be set to UART mode on its own.
// [R2] UART mode drives transmit, request-to-send and terminal-ready, handshakes active low.
// [R3] UART mode samples receive, clear-to-send, data-set-ready and carrier-detect inputs.
// [R4] Eighth UART line is ring-indicate input or line-driver enable output.
// [R5] Ring-indicate low with wake enabled signals resume to the suspended host.
// [R6] With the wake pull-down enabled, the ring line never ends suspend.
// [R7] Any channel can be a bit-bang port, synchronous or asynchronous, same pins.
// [R8] In bit-bang modes all eight lines are individually bidirectional data.
// [R9] Only channels A and B have the synchronous serial engine.
// [R10] Engine mode drives the serial clock output.
// [R11] Engine mode drives the serial data output.
// [R12] The target drives the engine data input in engine mode.
// [R13] Engine mode drives the select output.
// [R14] Engine mode leaves the upper four lines as software-driven GPIO.
// [R15] Channels C and D stay freely UART or bit-bang whatever A and B do.
// [R16] Ring-indicate versus line-driver choice comes from configuration; ring-indicate by default.
// [R17] Signals sit on bus bits 0 to 7 in listed order.
module qpm_pin_mux
    import qpm_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Configuration per channel
    input wire qpm_cfg_t [NUM_CHAN-1:0] chanCfg,
    input wire logic usbSuspended,
    // Function side outputs per channel
    input wire qpm_fn_out_t [NUM_CHAN-1:0] fnOut,
    // Function side inputs per channel, buffered
    output qpm_fn_in_t [NUM_CHAN-1:0] fnIn,
    output logic fnInValid,
    input wire logic fnInReady,
    // Wake request toward the USB side
    output logic resumeReq,
    // Channel buses A to D as split pins
    input wire logic [BUS_W-1:0] chanABusIn,
    input wire logic [BUS_W-1:0] chanBBusIn,
    input wire logic [BUS_W-1:0] chanCBusIn,
    input wire logic [BUS_W-1:0] chanDBusIn,
    output logic [BUS_W-1:0] chanABusOut,
    output logic [BUS_W-1:0] chanBBusOut,
    output logic [BUS_W-1:0] chanCBusOut,
    output logic [BUS_W-1:0] chanDBusOut,
    output logic [BUS_W-1:0] chanABusOe,
    output logic [BUS_W-1:0] chanBBusOe,
    output logic [BUS_W-1:0] chanCBusOe,
    output logic [BUS_W-1:0] chanDBusOe
);
    logic [NUM_CHAN-1:0][BUS_W-1:0] pinMeta_reg;
    logic [NUM_CHAN-1:0][BUS_W-1:0] pinSync_reg;
    logic [NUM_CHAN-1:0][BUS_W-1:0] busOut_reg;
    logic [NUM_CHAN-1:0][BUS_W-1:0] busOe_reg;
    logic [NUM_CHAN-1:0][BUS_W-1:0] busOut_next;
    logic [NUM_CHAN-1:0][BUS_W-1:0] busOe_next;
    qpm_fn_in_t [NUM_CHAN-1:0] fnIn_next;
    qpm_fn_in_t [NUM_CHAN-1:0] fifoOut;
    logic fifoInReady;
    logic fifoOutValid;
    logic fnInValid_reg;
    logic resume_reg;
    logic resume_next;
    qpm_fn_in_t [NUM_CHAN-1:0] fnIn_reg;

    // Engine mode is honoured only where an engine exists; elsewhere it falls back to UART.
    function automatic qpm_mode_t effMode(input int ch, input qpm_mode_t m);
        if (m == QPM_MODE_ENGINE && ch >= NUM_ENGINE) begin // see [R9] see [R15]
            return QPM_MODE_UART;
        end
        return m;
    endfunction : effMode

    // Pins come from outside, so two flops precede any use.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
        end else begin
            pinMeta_reg <= {chanDBusIn, chanCBusIn, chanBBusIn, chanABusIn};
            pinSync_reg <= pinMeta_reg;
        end
    end

    always_comb begin
        resume_next = 1'b0;
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            busOut_next[ch] = '0;
            busOe_next[ch] = '0;
            fnIn_next[ch] = '0;
            unique case (effMode(ch, chanCfg[ch].mode))
                QPM_MODE_UART: begin // see [R1]
                    busOut_next[ch][UART_TX_BIT] = fnOut[ch].uartTx; // see [R2] see [R17]
                    busOut_next[ch][UART_RTS_BIT] = fnOut[ch].uartRtsN; // see [R2]
                    busOut_next[ch][UART_DTR_BIT] = fnOut[ch].uartDtrN; // see [R2]
                    busOe_next[ch] = UART_OE_BASE;
                    fnIn_next[ch].uartRx = pinSync_reg[ch][UART_RX_BIT]; // see [R3]
                    fnIn_next[ch].uartCtsN = pinSync_reg[ch][UART_CTS_BIT]; // see [R3]
                    fnIn_next[ch].uartDsrN = pinSync_reg[ch][UART_DSR_BIT]; // see [R3]
                    fnIn_next[ch].carrierDetectN = pinSync_reg[ch][UART_DCD_BIT]; // see [R3]
                    if (chanCfg[ch].lineDriverSel) begin // see [R4] see [R16]
                        busOut_next[ch][UART_RING_BIT] = fnOut[ch].lineDriverEnable;
                        busOe_next[ch][UART_RING_BIT] = 1'b1;
                        fnIn_next[ch].ringIndicateN = 1'b1;
                    end else begin
                        fnIn_next[ch].ringIndicateN = pinSync_reg[ch][UART_RING_BIT];
                        // A pulled-down line would look like a ring forever, so it cannot wake.
                        if (usbSuspended && chanCfg[ch].wakeEnable && !chanCfg[ch].wakePulldown
                            && !pinSync_reg[ch][UART_RING_BIT]) begin // see [R5] see [R6]
                            resume_next = 1'b1;
                        end
                    end
                end
                QPM_MODE_BB_ASYNC, QPM_MODE_BB_SYNC: begin // see [R7]
                    busOut_next[ch] = fnOut[ch].bitbangOut; // see [R8]
                    busOe_next[ch] = fnOut[ch].bitbangOe; // see [R8]
                    fnIn_next[ch].bitbangIn = pinSync_reg[ch];
                end
                QPM_MODE_ENGINE: begin
                    busOut_next[ch][ENG_CLK_BIT] = fnOut[ch].engineClockOut; // see [R10]
                    busOut_next[ch][ENG_DOUT_BIT] = fnOut[ch].engineDataOut; // see [R11]
                    busOut_next[ch][ENG_SEL_BIT] = fnOut[ch].engineSelect; // see [R13]
                    busOut_next[ch][ENG_GPIO_LSB +: 4] = fnOut[ch].engineGpioOut; // see [R14]
                    busOe_next[ch] = ENG_OE_BASE | {fnOut[ch].engineGpioOe, 4'h0}; // see [R14]
                    fnIn_next[ch].engineDataIn = pinSync_reg[ch][ENG_DIN_BIT]; // see [R12]
                    fnIn_next[ch].engineGpioIn = pinSync_reg[ch][ENG_GPIO_LSB +: 4];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busOut_reg <= {NUM_CHAN{BUS_RESET_OUT}};
            busOe_reg <= '0;
        end else begin
            busOut_reg <= busOut_next;
            busOe_reg <= busOe_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= resume_next;
        end
    end

    // Snapshots of the input lines queue in order; once the FIFO is full, later samples are dropped until a read frees a slot.
    qpm_fifo #(
        .WIDTH(NUM_CHAN * FN_IN_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(1'b1),
        .inReady(fifoInReady),
        .inData(fnIn_next),
        .outValid(fifoOutValid),
        .outReady(fnInReady || !fnInValid_reg),
        .outData(fifoOut)
    );

    // Output stage holds one word so the port comes straight from a flop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fnIn_reg <= '0;
            fnInValid_reg <= 1'b0;
        end else if (fnInReady || !fnInValid_reg) begin
            fnIn_reg <= fifoOut;
            fnInValid_reg <= fifoOutValid;
        end
    end

    assign fnIn = fnIn_reg;
    assign fnInValid = fnInValid_reg;
    assign resumeReq = resume_reg;
    assign chanABusOut = busOut_reg[0];
    assign chanBBusOut = busOut_reg[1];
    assign chanCBusOut = busOut_reg[2];
    assign chanDBusOut = busOut_reg[3];
    assign chanABusOe = busOe_reg[0];
    assign chanBBusOe = busOe_reg[1];
    assign chanCBusOe = busOe_reg[2];
    assign chanDBusOe = busOe_reg[3];
endmodule : qpm_pin_mux

// ===== verification/qpm_pin_mux_chk.sv
`timescale 1ns/100ps
module qpm_pin_mux_chk
    import qpm_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control side
    input wire qpm_cfg_t [NUM_CHAN-1:0] chanCfg,
    input wire logic usbSuspended,
    input wire qpm_fn_out_t [NUM_CHAN-1:0] fnOut,
    input wire qpm_fn_in_t [NUM_CHAN-1:0] fnIn,
    input wire logic fnInValid,
    input wire logic fnInReady,
    input wire logic resumeReq,
    // Pins
    input wire logic [BUS_W-1:0] chanABusIn,
    input wire logic [BUS_W-1:0] chanABusOut,
    input wire logic [BUS_W-1:0] chanBBusOut,
    input wire logic [BUS_W-1:0] chanDBusOut,
    input wire logic [BUS_W-1:0] chanBBusOe,
    input wire logic [BUS_W-1:0] chanCBusOe,
    input wire logic [BUS_W-1:0] chanDBusOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_uart_pins: assert property (
        chanCfg[0].mode == QPM_MODE_UART |=> chanABusOut[0] == $past(fnOut[0].uartTx)
        && chanABusOut[2] == $past(fnOut[0].uartRtsN) && chanABusOut[4] == $past(fnOut[0].uartDtrN))
        else $error("bad uart outputs");
    a_uart_dirs: assert property (
        chanCfg[2].mode == QPM_MODE_UART && !chanCfg[2].lineDriverSel |=> chanCBusOe == 8'h15)
        else $error("bad uart directions");
    a_line_driver: assert property (
        chanCfg[3].mode == QPM_MODE_UART && chanCfg[3].lineDriverSel
        |=> chanDBusOe == 8'h95 && chanDBusOut[7] == $past(fnOut[3].lineDriverEnable))
        else $error("bad line driver");
    a_engine_pins: assert property (
        chanCfg[1].mode == QPM_MODE_ENGINE |=> chanBBusOe == {$past(fnOut[1].engineGpioOe), 4'hb}
        && {chanBBusOut[3], chanBBusOut[1:0]} == {$past(fnOut[1].engineSelect),
        $past(fnOut[1].engineDataOut), $past(fnOut[1].engineClockOut)})
        else $error("bad engine pins");
    a_engine_refused: assert property (
        chanCfg[2].mode == QPM_MODE_ENGINE && !chanCfg[2].lineDriverSel |=> chanCBusOe == 8'h15)
        else $error("engine on channel c");
    a_bitbang_pins: assert property (
        chanCfg[3].mode inside {QPM_MODE_BB_ASYNC, QPM_MODE_BB_SYNC}
        |=> chanDBusOut == $past(fnOut[3].bitbangOut) && chanDBusOe == $past(fnOut[3].bitbangOe))
        else $error("bad bitbang pins");
    a_ring_wake: assert property (
        (usbSuspended && chanCfg[0].mode == QPM_MODE_UART && !chanCfg[0].lineDriverSel
        && chanCfg[0].wakeEnable && !chanCfg[0].wakePulldown && !chanABusIn[7]) [*4] |=> resumeReq)
        else $error("no resume");
    // A held snapshot must not slip, or the consumer would miss a pin change.
    a_snap_hold: assert property (fnInValid && !fnInReady |=> fnInValid && $stable(fnIn))
        else $error("snapshot moved");
endmodule : qpm_pin_mux_chk
bind qpm_pin_mux qpm_pin_mux_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .resetn, .chanCfg, .usbSuspended,
    .fnOut, .fnIn, .fnInValid, .fnInReady, .resumeReq, .chanABusIn, .chanABusOut, .chanBBusOut,
    .chanDBusOut, .chanBBusOe, .chanCBusOe, .chanDBusOe);

// ===== verification/qpm_far_side.sv
`timescale 1ns/100ps
module qpm_far_side (
    // Device side of the four buses
    input wire logic [3:0][7:0] busOut,
    input wire logic [3:0][7:0] busOe,
    // Levels the peripherals put on the lines
    input wire logic [3:0][7:0] periphDrive,
    // Resolved wires
    output logic [3:0][7:0] busIn
);
    // Peripherals yield every line the device drives, so no fight is modelled.
    assign busIn = (busOut & busOe) | (periphDrive & ~busOe);
endmodule : qpm_far_side

// ===== verification/quad_channel_mode_pin_mux_tb.sv
`timescale 1ns/100ps
module quad_channel_mode_pin_mux_tb
    import qpm_pkg::*;
;
    logic clk, resetn, usbSuspended, fnInReady, fnInValid, resumeReq;
    qpm_cfg_t [NUM_CHAN-1:0] chanCfg;
    qpm_fn_out_t [NUM_CHAN-1:0] fnOut;
    qpm_fn_in_t [NUM_CHAN-1:0] fnIn;
    wire logic [3:0][7:0] busOut, busOe, busIn;
    logic [3:0][7:0] periph;
    int failures, tests_run;
    qpm_pin_mux #(.FIFO_DEPTH(8)) uut (.clk(clk), .resetn(resetn), .chanCfg(chanCfg), .usbSuspended(usbSuspended),
        .fnOut(fnOut), .fnIn(fnIn), .fnInValid(fnInValid), .fnInReady(fnInReady), .resumeReq(resumeReq),
        .chanABusIn(busIn[0]), .chanBBusIn(busIn[1]), .chanCBusIn(busIn[2]), .chanDBusIn(busIn[3]),
        .chanABusOut(busOut[0]), .chanBBusOut(busOut[1]), .chanCBusOut(busOut[2]), .chanDBusOut(busOut[3]),
        .chanABusOe(busOe[0]), .chanBBusOe(busOe[1]), .chanCBusOe(busOe[2]), .chanDBusOe(busOe[3]));
    qpm_far_side peer (.busOut(busOut), .busOe(busOe), .periphDrive(periph), .busIn(busIn));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wait_valid;
        for (int i = 0; i < 20 && fnInValid !== 1'b1; i++) @(negedge clk);
        if (fnInValid !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask : wait_valid
    initial begin
        failures = 0;
        tests_run = 0;
        resetn = 1'b0;
        usbSuspended = 1'b0;
        fnInReady = 1'b1;
        chanCfg = '0;
        fnOut = '0;
        periph = {4{8'hff}};
        cyc(8);
        check("reset out", busOut[1], 8'hff);
        check("reset oe", busOe[1], 8'h00);
        resetn = 1'b1;
        for (int c = 0; c < 4; c++) begin
            fnOut[c].uartTx = c[0];
            fnOut[c].uartRtsN = c[1];
            fnOut[c].uartDtrN = 1'b1;
        end
        periph[0] = 8'h28;
        cyc(2);
        for (int c = 0; c < 4; c++) begin
            check("uart oe", busOe[c], 8'h15);
            check("uart out", busOut[c] & 8'h15, {3'h0, 1'b1, 1'b0, c[1], 1'b0, c[0]});
        end
        wait_valid();
        cyc(8);
        check("modem in", {4'h0, fnIn[0].uartRx, fnIn[0].uartCtsN, fnIn[0].uartDsrN, fnIn[0].carrierDetectN},
            8'h06);
        chanCfg[3].lineDriverSel = 1'b1;
        fnOut[3].lineDriverEnable = 1'b1;
        cyc(2);
        check("drv oe", busOe[3], 8'h95);
        check("drv out", {7'h0, busOut[3][7]}, 8'h01);
        usbSuspended = 1'b1;
        chanCfg[0].wakeEnable = 1'b1;
        cyc(6);
        check("wake", {7'h0, resumeReq}, 8'h01);
        for (int c = 0; c < 4; c++) chanCfg[c].wakePulldown = 1'b1;
        cyc(6);
        check("pulldown", {7'h0, resumeReq}, 8'h00);
        usbSuspended = 1'b0;
        // Channel C asks for the engine it lacks; it must stay a UART.
        for (int c = 0; c < 3; c++) begin
            chanCfg[c].mode = QPM_MODE_ENGINE;
            fnOut[c].engineClockOut = 1'b1;
            fnOut[c].engineSelect = 1'b1;
            fnOut[c].engineGpioOut = 4'ha;
            fnOut[c].engineGpioOe = 4'hc;
        end
        chanCfg[3].mode = QPM_MODE_BB_SYNC;
        fnOut[3].bitbangOut = 8'h5a;
        fnOut[3].bitbangOe = 8'h0f;
        periph[0] = 8'h34;
        periph[3] = 8'ha5;
        cyc(2);
        for (int c = 0; c < 2; c++) begin
            check("eng oe", busOe[c], 8'hcb);
            check("eng out", busOut[c] & busOe[c], 8'h89);
        end
        check("eng on c", busOe[2], 8'h15);
        check("bb out", busOut[3], 8'h5a);
        check("bb oe", busOe[3], 8'h0f);
        cyc(8);
        check("eng in", {6'h0, fnIn[0].engineDataIn, fnIn[0].engineGpioIn[0]}, 8'h03);
        check("bb in", fnIn[3].bitbangIn, 8'haa);
        chanCfg[3].mode = QPM_MODE_BB_ASYNC;
        fnInReady = 1'b0;
        cyc(3);
        check("bb async", busOut[3], 8'h5a);
        periph[3] = 8'h55;
        cyc(20);
        check("held valid", {7'h0, fnInValid}, 8'h01);
        check("held", fnIn[3].bitbangIn, 8'haa);
        fnInReady = 1'b1;
        cyc(20);
        check("drained", fnIn[3].bitbangIn, 8'h5a);
        wrap_up();
    end
endmodule : quad_channel_mode_pin_mux_tb
